//--- rtl/pst_frame_counter.sv
// Remaining-bit-time down counter of the frame
`timescale 1ns/1ns
`default_nettype none
module pst_frame_counter #(
  parameter int W = 14
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic         bit_tick,
  input  wire logic         run,
  input  wire logic [W-1:0] interval_length_value,
  output logic [W-1:0]      bit_time_left_count,
  output logic              frame_wrap
);
  typedef struct packed {
    logic [W-1:0] count;
    logic         wrap;
  } pst_fc_s;

  pst_fc_s state;
  pst_fc_s next_state;

  // Decrement per bit time, reload after reaching zero
  always_comb begin
    next_state      = state;
    next_state.wrap = 1'b0;
    if (!run) begin
      next_state.count = interval_length_value;
    end else if (bit_tick) begin
      if (state.count == '0) begin
        next_state.count = interval_length_value;
        next_state.wrap  = 1'b1;
      end else begin
        next_state.count = state.count - 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign bit_time_left_count = state.count;
  assign frame_wrap          = state.wrap;

  chk_wrap_reload: assert property (@(posedge clk) disable iff (reset)
    (run && bit_tick && state.count == '0) |=> (state.count == $past(interval_length_value)))
    else $error("counter did not reload after zero");
  chk_count_step: assert property (@(posedge clk) disable iff (reset)
    (run && bit_tick && state.count != '0) |=> (state.count == $past(state.count) - 1'b1))
    else $error("counter did not step down by one");
endmodule
`default_nettype wire

//--- rtl/pst_frame_timing.sv
// Periodic-start and low-speed threshold decisions with their registers
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - Periodic start is 14 bits at 13:0, cleared on hardware reset.
// - Counter at or below periodic start: periodic lists win for rest of frame.
// - Running control or bulk transaction finishes first; never aborted.
// - Low-speed start allowed only when remaining count >= threshold.
// - Threshold is bits 11:0, resets to 0x628.
// - Threshold decides if an 8-byte low-speed packet fits before frame end.
// - Remaining count is a 14-bit down counter reloaded from interval.
module pst_frame_timing #(
  parameter int BT_W  = pst_pkg::BT_W,
  parameter int LST_W = pst_pkg::LST_W
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire pst_pkg::pst_req_s req,
  output logic [31:0]            rdata,
  output logic                   rvalid,
  input  wire logic              bit_tick,
  input  wire logic              run,
  input  wire logic [BT_W-1:0]   interval_length_value,
  input  wire logic              nonperiodic_busy,
  input  wire logic              ls_request,
  output logic                   periodic_priority,
  output logic                   periodic_grant,
  output logic                   ls_start_ok,
  output logic [BT_W-1:0]        bit_time_left_count
);
  typedef struct packed {
    logic [BT_W-1:0]     periodic_begin_point;
    logic [LST_W-1:0]    slow_commit_limit;
    logic [31:0]         rdata;
    logic                rvalid;
    pst_pkg::pst_phase_e phase;
    logic                periodic_priority;
    logic                periodic_grant;
    logic                ls_start_ok;
    logic [BT_W-1:0]     count_q;
  } pst_ft_s;

  pst_ft_s         state;
  pst_ft_s         next_state;
  logic [BT_W-1:0] count;
  logic            frame_wrap;
  logic            start_hit;
  logic            ls_fits;

  // Counter lives in its own module; both comparators read it
  pst_frame_counter #(.W(BT_W)) u_counter (
    .clk                   (clk),
    .reset                 (reset),
    .bit_tick              (bit_tick),
    .run                   (run),
    .interval_length_value (interval_length_value),
    .bit_time_left_count   (count),
    .frame_wrap            (frame_wrap)
  );

  // Zero-extend a counter-wide field into a 32-bit read word
  function automatic logic [31:0] pst_zx14(input logic [BT_W-1:0] v);
    pst_zx14 = 32'(v);
  endfunction

  // Write strobe aimed at one offset; shared by the register file and checks
  function automatic logic pst_wr_hit(input pst_pkg::pst_req_s r, input logic [7:0] off);
    pst_wr_hit = r.wr && (r.addr == off);
  endfunction

  // Comparators: a down counter passes the start point once per frame
  assign start_hit = (count <= state.periodic_begin_point);
  assign ls_fits   = (BT_W'(state.slow_commit_limit) <= count);

  // Register file, phase machine and decision outputs
  always_comb begin
    next_state        = state;
    next_state.rvalid = req.rd;
    next_state.rdata  = 32'h00000000;
    next_state.count_q = count;
    // Only the field bits are stored; reserved bits are dropped
    if (pst_wr_hit(req, pst_pkg::OFF_PERIODIC_START)) begin
      next_state.periodic_begin_point = req.wdata[BT_W-1:0];
    end
    if (pst_wr_hit(req, pst_pkg::OFF_LS_THRESHOLD)) begin
      next_state.slow_commit_limit = req.wdata[LST_W-1:0];
    end
    if (req.rd) begin
      unique case (req.addr)
        pst_pkg::OFF_PERIODIC_START: next_state.rdata = pst_zx14(state.periodic_begin_point);
        pst_pkg::OFF_LS_THRESHOLD:   next_state.rdata = 32'(state.slow_commit_limit);
        default:                     next_state.rdata = 32'h00000000;
      endcase
    end
    // Phase: grant handed over only after the current transaction ends
    unique case (state.phase)
      pst_pkg::PST_NONPERIODIC: begin
        if (run && start_hit) begin
          next_state.phase = nonperiodic_busy ? pst_pkg::PST_DRAIN
                                              : pst_pkg::PST_PERIODIC;
        end
      end
      pst_pkg::PST_DRAIN: begin
        if (!nonperiodic_busy) begin
          next_state.phase = pst_pkg::PST_PERIODIC;
        end
      end
      pst_pkg::PST_PERIODIC: begin
        next_state.phase = pst_pkg::PST_PERIODIC;
      end
      default: next_state.phase = pst_pkg::PST_NONPERIODIC;
    endcase
    // New frame or stopped controller returns to non-periodic order
    if (frame_wrap || !run) begin
      next_state.phase = pst_pkg::PST_NONPERIODIC;
    end
    next_state.periodic_priority = (next_state.phase != pst_pkg::PST_NONPERIODIC);
    next_state.periodic_grant    = (next_state.phase == pst_pkg::PST_PERIODIC);
    next_state.ls_start_ok       = run && ls_request && ls_fits;
  end

  // Reset loads the field reset values; everything else clears
  always_ff @(posedge clk) begin
    if (reset) begin
      state                      <= '0;
      state.periodic_begin_point <= pst_pkg::PSP_RESET;
      state.slow_commit_limit    <= pst_pkg::LST_RESET;
      state.phase                <= pst_pkg::PST_NONPERIODIC;
    end else begin
      state <= next_state;
    end
  end

  // Every output comes straight from the state register
  assign rdata               = state.rdata;
  assign rvalid              = state.rvalid;
  assign periodic_priority   = state.periodic_priority;
  assign periodic_grant      = state.periodic_grant;
  assign ls_start_ok         = state.ls_start_ok;
  assign bit_time_left_count = state.count_q;

  // Reset values of both fields, seen at every edge after a reset edge
  chk_psp_reset: assert property (@(posedge clk)
    $past(reset) |-> state.periodic_begin_point == pst_pkg::PSP_RESET)
    else $error("periodic start not cleared by reset");
  chk_lst_reset: assert property (@(posedge clk)
    $past(reset) |-> state.slow_commit_limit == pst_pkg::LST_RESET)
    else $error("threshold reset value wrong");

  // Arbitration: priority rises at the start point and holds to frame end
  chk_prio_hold: assert property (@(posedge clk) disable iff (reset)
    (periodic_priority && run && !frame_wrap) |=> periodic_priority)
    else $error("periodic priority dropped mid frame");
  // Start point reached while running raises priority one edge later
  chk_prio_rise: assert property (@(posedge clk) disable iff (reset)
    (run && start_hit && !frame_wrap) |=> periodic_priority)
    else $error("periodic priority not raised at start point");
  // Reload of the counter hands the frame back to control and bulk lists
  chk_wrap_clear: assert property (@(posedge clk) disable iff (reset)
    frame_wrap |=> !periodic_priority && !periodic_grant)
    else $error("priority kept across frame boundary");
  // Stopped controller keeps every decision low
  chk_run_idle: assert property (@(posedge clk) disable iff (reset)
    !run |=> !periodic_priority && !periodic_grant && !ls_start_ok)
    else $error("decision raised while stopped");

  // Transaction in progress is never cut short by the hand-over
  chk_no_abort: assert property (@(posedge clk) disable iff (reset)
    (state.phase == pst_pkg::PST_DRAIN && nonperiodic_busy && run && !frame_wrap)
      |=> !periodic_grant)
    else $error("periodic grant while transaction in progress");
  // Draining ends on the edge after the transaction is done
  chk_drain_exit: assert property (@(posedge clk) disable iff (reset)
    (state.phase == pst_pkg::PST_DRAIN && !nonperiodic_busy && run && !frame_wrap)
      |=> periodic_grant)
    else $error("periodic grant late after transaction end");
  // Grant never runs ahead of priority
  chk_grant_prio: assert property (@(posedge clk) disable iff (reset)
    periodic_grant |-> periodic_priority)
    else $error("periodic grant without priority");

  // Low-speed gate follows the threshold compare one edge later
  chk_ls_gate: assert property (@(posedge clk) disable iff (reset)
    ls_start_ok |-> $past(BT_W'(state.slow_commit_limit) <= count && ls_request))
    else $error("low-speed start below threshold");
  chk_ls_allow: assert property (@(posedge clk) disable iff (reset)
    (run && ls_request && BT_W'(state.slow_commit_limit) <= count) |=> ls_start_ok)
    else $error("low-speed start withheld");
  // Too few bit times left must block the start
  chk_ls_block: assert property (@(posedge clk) disable iff (reset)
    (BT_W'(state.slow_commit_limit) > count) |=> !ls_start_ok)
    else $error("low-speed start with too few bit times");

  // Register bus: writes land at the taking edge, reads answer one edge later
  chk_psp_write: assert property (@(posedge clk) disable iff (reset)
    pst_wr_hit(req, pst_pkg::OFF_PERIODIC_START)
      |=> state.periodic_begin_point == $past(req.wdata[BT_W-1:0]))
    else $error("periodic start write lost");
  // Only the twelve field bits of a threshold write are kept
  chk_lst_write: assert property (@(posedge clk) disable iff (reset)
    pst_wr_hit(req, pst_pkg::OFF_LS_THRESHOLD)
      |=> state.slow_commit_limit == $past(req.wdata[LST_W-1:0]))
    else $error("threshold write lost");
  // Read shows the value held when the strobe was taken
  chk_psp_read: assert property (@(posedge clk) disable iff (reset)
    (req.rd && req.addr == pst_pkg::OFF_PERIODIC_START)
      |=> rdata == pst_zx14($past(state.periodic_begin_point)))
    else $error("periodic start read wrong");
  // A strobe held during reset is not answered, so skip that edge
  chk_read_pulse: assert property (@(posedge clk) disable iff (reset)
    !$past(reset) |-> rvalid == $past(req.rd))
    else $error("read answer missing or spurious");
  chk_rsvd_zero: assert property (@(posedge clk) disable iff (reset)
    rvalid |-> rdata[31:BT_W] == '0)
    else $error("reserved bits read nonzero");
  // Threshold reads show zero above its field, bits 13 and 12 included
  chk_lst_rsvd: assert property (@(posedge clk) disable iff (reset)
    (rvalid && $past(req.addr) == pst_pkg::OFF_LS_THRESHOLD) |-> rdata[31:LST_W] == '0)
    else $error("threshold reserved bits read nonzero");
endmodule
`default_nettype wire

//--- shared/pst_pkg.sv
// Package for the periodic-start and low-speed threshold block
package pst_pkg;
  // Register offsets (byte addresses within the controller register space)
  localparam logic [7:0]  OFF_PERIODIC_START = 8'h40;
  localparam logic [7:0]  OFF_LS_THRESHOLD   = 8'h44;
  // Field widths
  localparam int          BT_W   = 14;
  localparam int          LST_W  = 12;
  // Reset values
  localparam logic [13:0] PSP_RESET = 14'h0000;
  localparam logic [11:0] LST_RESET = 12'h628;
  localparam logic [13:0] FI_RESET  = 14'h2edf;

  // Register access request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } pst_req_s;

  // Scheduler arbitration phase within a frame
  typedef enum logic [1:0] {
    PST_NONPERIODIC = 2'b00,
    PST_DRAIN       = 2'b01,
    PST_PERIODIC    = 2'b11
  } pst_phase_e;
endpackage

//--- test/pst_testbench.sv
// Self-checking bench for the periodic-start and low-speed threshold block
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic              clk, reset, bit_tick, run, busy, ls_req, rvalid, prio, grant, ls_ok;
  logic [31:0]       rdata;
  logic [13:0]       ivl, left;
  pst_pkg::pst_req_s req;
  int                bad_count, total_checks, cycles, cnt, psp, slow_packet_threshold, pr, gr, iv;

  pst_frame_timing u_dut (.clk(clk), .reset(reset), .req(req), .rdata(rdata),
    .rvalid(rvalid), .bit_tick(bit_tick), .run(run), .interval_length_value(ivl),
    .nonperiodic_busy(busy), .ls_request(ls_req), .periodic_priority(prio),
    .periodic_grant(grant), .ls_start_ok(ls_ok), .bit_time_left_count(left));

  // Free-running 8 ns clock
  always #4 clk = ~clk;

  // Hang guard, well above the under 1500 cycles the run needs
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Single-cycle strobes; write lands at the taking edge
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk) req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk) req <= '0;
  endtask

  // Read answer stands one cycle, so it is sampled just after the taking edge
  task automatic rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clk) req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clk) req <= '0;
    #1;
    check("rvalid", rvalid, 1);
    check("rdata", rdata, exp);
  endtask

  // Outputs compared only after the count has stood still a few cycles
  task automatic check_all();
    repeat (3) @(posedge clk);
    #1;
    check("count", left, cnt);
    check("ls_ok", ls_ok, run && ls_req && cnt >= slow_packet_threshold);
    check("prio", prio, pr);
    check("grant", grant, gr);
  endtask

  // Burst of n bit times with the model stepped alongside
  // Grant, once given, stays until the frame reloads even if busy returns
  task automatic ticks(int n, logic b, logic l);
    @(posedge clk) busy <= b;
    ls_req <= l;
    repeat (n) begin
      @(posedge clk) bit_tick <= 1'b1;
      if (cnt == 0) begin
        cnt = ivl;
        pr = 0;
        gr = 0;
      end else cnt--;
      if (cnt <= psp) pr = 1;
      if (pr && !b) gr = 1;
    end
    @(posedge clk) bit_tick <= 1'b0;
    if (pr && !b) gr = 1;
    check_all();
  endtask

  initial begin
    {clk, bit_tick, run, busy, ls_req, bad_count, total_checks, cycles} = '0;
    reset = 1'b1;
    req = '0;
    ivl = 14'h0;
    void'($urandom(32'h2793970d));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(pst_pkg::OFF_PERIODIC_START, 32'h0);
    rd(pst_pkg::OFF_LS_THRESHOLD, 32'h628);
    rd(8'h48, 32'h0);
    ls_req <= 1'b1;
    // Pass 0 keeps a zero start point, pass 1 one near a tenth of the interval
    for (int p = 0; p < 2; p++) begin
      @(posedge clk) run <= 1'b0;
      iv = 60 + $urandom % 40;
      ivl <= 14'(iv);
      psp = p ? iv / 10 + $urandom % 3 : 0;
      slow_packet_threshold = $urandom % 60;
      // Reserved bits always written as zero
      wr(pst_pkg::OFF_PERIODIC_START, psp);
      wr(pst_pkg::OFF_LS_THRESHOLD, slow_packet_threshold);
      rd(pst_pkg::OFF_PERIODIC_START, psp);
      rd(pst_pkg::OFF_LS_THRESHOLD, slow_packet_threshold);
      cnt = iv;
      pr = 0;
      gr = 0;
      check_all();
      @(posedge clk) run <= 1'b1;
      check_all();
      for (int k = 0; k < 40; k++) ticks(1 + $urandom % 9, $urandom % 2, $urandom % 2);
      // Long hold of the busy flag across the start point
      ticks(iv, 1'b1, 1'b1);
      ticks(1, 1'b0, 1'b1);
    end
    // Second reset in mid-run brings both fields back
    @(posedge clk) reset <= 1'b1;
    run <= 1'b0;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    rd(pst_pkg::OFF_PERIODIC_START, 32'h0);
    rd(pst_pkg::OFF_LS_THRESHOLD, 32'h628);
    close_out();
  end
endmodule
`default_nettype wire
